/* File: design/phy_diag_pkg.sv */
/*
 * Shared constants and carrier types for the physical-layer diagnostic
 * status block: register offsets, field positions, reset values.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package phy_diag_pkg;

    localparam int NUM_PORTS = 4;
    localparam int NUM_LANES = 4;

    // Register byte offsets
    localparam logic [11:0] OFF_RX_ERR     = 12'h248;
    localparam logic [11:0] OFF_TGT_WIDTH  = 12'h24C;
    localparam logic [11:0] OFF_PHY_EXTRA  = 12'h254;
    localparam logic [11:0] OFF_PAT_SYNC   = 12'h258;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h270;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h274;
    localparam logic [11:0] OFF_PAT_CTRL   = 12'h278;

    // Field positions
    localparam int TW_UPCFG_BIT    = 7;
    localparam int PX_PHYST_LSB    = 4;
    localparam int PX_MCERR_LSB    = 8;
    localparam int PX_MCLOCK_BIT   = 15;
    localparam int PX_EXTLB_LSB    = 16;
    localparam int PX_RXDET_LSB    = 20;
    localparam int PX_MCSEL_LSB    = 24;
    localparam int PS_INVERT_BIT   = 16;
    localparam int PC_GEN_EN_BIT   = 0;
    localparam int PC_CHK_EN_BIT   = 1;
    localparam int PC_ERRCNT_LSB   = 8;

    // Reset values and limits
    localparam logic [7:0] CNT_RST  = 8'h00;
    localparam logic [7:0] CNT_MAX  = 8'hFF;
    localparam logic [6:0] MC_RST   = 7'h00;
    localparam logic [6:0] MC_MAX   = 7'h7F;
    localparam logic [6:0] PRBS_SEED = 7'h7F;
    localparam int SYNC_MATCHES = 2;

    // Interrupt status layout: one bit per port for each event group
    localparam int IRQ_LBFAIL_LSB = 0;
    localparam int IRQ_SYNC_LSB   = 4;
    localparam int IRQ_SAT_LSB    = 8;
    localparam int IRQ_WIDTH      = 12;

    typedef struct packed {
        logic [3:0] rx_err;
        logic [3:0] lb_fail;
        logic [3:0] upcfg_seen;
        logic [3:0] training;
        logic [3:0] retrain_req;
        logic [7:0] neg_width;
        logic [7:0] cur_width;
        logic [3:0] ready_lb_master;
    } port_event_type;

    typedef struct packed {
        logic [3:0] ltssm_to_cfg;
        logic [7:0] target_width;
        logic [3:0] ext_loopback;
        logic [3:0] lb_after_fail;
    } port_ctrl_type;

    typedef struct packed {
        logic [3:0] phy_status;
        logic       mc_err;
        logic       mc_lock;
    } lane_status_type;

endpackage

/* File: design/phy_link_diagnostic_status.sv */
/*
 * Physical-layer diagnostic and link-control status for four ports and
 * four lanes, reached over a classic Wishbone slave.  Assumes the link
 * state machines report events as one-cycle pulses on clk_sys.
 */
// Local design decision: the Wishbone interface to the registers.
// What this block does
// RQ1 - Each port keeps an 8-bit receiver error count in its own byte.
// RQ2 - A write to a count byte clears it; the counts are otherwise RO.
// RQ3 - Each detected receiver error adds exactly one until saturation.
// RQ4 - Target link width loads from the width negotiated in training.
// RQ5 - Software loads a width no wider than negotiated, then retrains.
// RQ6 - Retrain with a new target width sends the port to configuration.
// RQ7 - Bit 7 flags that the partner advertised upconfigure capability.
// RQ8 - A failed loopback-master entry sets a W1C flag in bits 0 to 3.
// RQ9 - Failure flag plus ready-as-master means loopback after failure.
// RQ10 - Bits 7:4 mirror the PIPE PhyStatus of the lanes.
// RQ11 - Compliance errors at 14:8, lock at 15, lane select at 25:24.
// RQ12 - External loopback enables in bits 16 to 19 allow link up.
// RQ13 - Software sets external loopback when a port is wired to itself.
// RQ14 - A lane asserts sync after two consecutive matching words.
// RQ15 - A checker neither detects nor counts errors before sync.
// RQ16 - The generator emits PRBS7, or its complement when bit 16 is set.
// RQ17 - The shared checker count saturates and clears when disabled.
`timescale 1ns/1ps

module phy_link_diagnostic_status (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [11:0]                  wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    input  wire phy_diag_pkg::port_event_type port_evt,
    input  wire phy_diag_pkg::lane_status_type lane_st,
    input  wire logic [3:0]                   rx_valid,
    input  wire logic [27:0]                  rx_words,
    output phy_diag_pkg::port_ctrl_type       port_ctrl,
    output logic [6:0]                        tx_word,
    output logic                              irq
);

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] rxerr_r,  rxerr_nxt;
    logic [7:0]  tgtw_r,   tgtw_nxt;
    logic [3:0]  upcfg_r,  upcfg_nxt;
    logic [3:0]  lbfail_r, lbfail_nxt;
    logic [3:0]  extlb_r,  extlb_nxt;
    logic [3:0]  rxdet_r,  rxdet_nxt;
    logic [1:0]  mcsel_r,  mcsel_nxt;
    logic [6:0]  mccnt_r,  mccnt_nxt;
    logic        mclock_r, mclock_nxt;
    logic        inv_r,    inv_nxt;
    logic        gen_en_r, gen_en_nxt;
    logic        chk_en_r, chk_en_nxt;
    logic [7:0]  chkcnt_r, chkcnt_nxt;
    logic [6:0]  prbs_r,   prbs_nxt;
    logic [6:0]  tx_r,     tx_nxt;
    logic [3:0]  cfg_r,    cfg_nxt;
    logic [11:0] ists_r,   ists_nxt;
    logic [11:0] imask_r,  imask_nxt;
    logic [31:0] rdat_r,   rdat_nxt;
    logic        ack_r,    ack_nxt;
    logic [3:0]  sync_w,   err_w;
    logic [3:0]  rxclr_w;
    logic [3:0]  sync_d_r;
    logic [3:0]  sat_evt;
    logic        wr_go,    rd_go;
    logic [31:0] rd_mux;

    default clocking chk_clk @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    // Pattern checkers, one per lane
    genvar g;
    generate
        for (g = 0; g < phy_diag_pkg::NUM_LANES; g++) begin : g_lane
            prbs_lane_checker u_chk (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .enable    (chk_en_r),
                .invert    (inv_r),
                .rx_valid  (rx_valid[g]),
                .rx_word   (rx_words[g*7 +: 7]),
                .sync      (sync_w[g]),
                .err_pulse (err_w[g])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////
    // Bus decode: one access per request, ack drops after one cycle
    assign wr_go = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
    assign rd_go = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;
    assign rxclr_w = wb_sel_i
        & {4{wr_go && wb_adr_i == phy_diag_pkg::OFF_RX_ERR}};
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            phy_diag_pkg::OFF_RX_ERR:    rd_mux = rxerr_r;
            phy_diag_pkg::OFF_TGT_WIDTH: begin
                rd_mux[1:0] = tgtw_r[1:0];
                rd_mux[phy_diag_pkg::TW_UPCFG_BIT] = upcfg_r[0]; // RQ7
                rd_mux[15:8] = {6'h00, tgtw_r[3:2]};
                rd_mux[phy_diag_pkg::TW_UPCFG_BIT + 8] = upcfg_r[1];
                rd_mux[17:16] = tgtw_r[5:4];
                rd_mux[phy_diag_pkg::TW_UPCFG_BIT + 16] = upcfg_r[2];
                rd_mux[25:24] = tgtw_r[7:6];
                rd_mux[phy_diag_pkg::TW_UPCFG_BIT + 24] = upcfg_r[3];
            end
            phy_diag_pkg::OFF_PHY_EXTRA: begin
                rd_mux[3:0] = lbfail_r;
                rd_mux[phy_diag_pkg::PX_PHYST_LSB +: 4] =
                    lane_st.phy_status; // RQ10
                rd_mux[phy_diag_pkg::PX_MCERR_LSB +: 7] = mccnt_r; // RQ11
                rd_mux[phy_diag_pkg::PX_MCLOCK_BIT] = mclock_r; // RQ11
                rd_mux[phy_diag_pkg::PX_EXTLB_LSB +: 4] = extlb_r;
                rd_mux[phy_diag_pkg::PX_RXDET_LSB +: 4] = rxdet_r;
                rd_mux[phy_diag_pkg::PX_MCSEL_LSB +: 2] = mcsel_r; // RQ11
            end
            phy_diag_pkg::OFF_PAT_SYNC: begin
                rd_mux[3:0] = sync_w; // RQ14
                rd_mux[phy_diag_pkg::PS_INVERT_BIT] = inv_r;
            end
            phy_diag_pkg::OFF_IRQ_STATUS: rd_mux[11:0] = ists_r;
            phy_diag_pkg::OFF_IRQ_MASK:   rd_mux[11:0] = imask_r;
            phy_diag_pkg::OFF_PAT_CTRL: begin
                rd_mux[phy_diag_pkg::PC_GEN_EN_BIT] = gen_en_r;
                rd_mux[phy_diag_pkg::PC_CHK_EN_BIT] = chk_en_r;
                rd_mux[phy_diag_pkg::PC_ERRCNT_LSB +: 8] = chkcnt_r;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        rxerr_nxt  = rxerr_r;
        tgtw_nxt   = tgtw_r;
        upcfg_nxt  = upcfg_r;
        lbfail_nxt = lbfail_r;
        extlb_nxt  = extlb_r;
        rxdet_nxt  = rxdet_r;
        mcsel_nxt  = mcsel_r;
        mccnt_nxt  = mccnt_r;
        mclock_nxt = lane_st.mc_lock;
        inv_nxt    = inv_r;
        gen_en_nxt = gen_en_r;
        chk_en_nxt = chk_en_r;
        chkcnt_nxt = chkcnt_r;
        imask_nxt  = imask_r;
        ists_nxt   = ists_r;
        cfg_nxt    = 4'h0;
        sat_evt    = 4'h0;
        ack_nxt    = wr_go || rd_go;
        rdat_nxt   = rd_go ? rd_mux : rdat_r;
        // Status bits are cleared by a read; new events below still win
        if (rd_go && wb_adr_i == phy_diag_pkg::OFF_IRQ_STATUS) begin
            ists_nxt = 12'h000;
        end
        for (int p = 0; p < phy_diag_pkg::NUM_PORTS; p++) begin
            // Clear by write to the byte lane, regardless of data
            if (rxclr_w[p]) begin
                rxerr_nxt[p*8 +: 8] = phy_diag_pkg::CNT_RST; // RQ2
            end else if (port_evt.rx_err[p]
                && rxerr_r[p*8 +: 8] != phy_diag_pkg::CNT_MAX) begin
                rxerr_nxt[p*8 +: 8] = rxerr_r[p*8 +: 8] + 8'h01; // RQ3
                if (rxerr_r[p*8 +: 8] == 8'hFE) begin
                    sat_evt[p] = 1'b1; // RQ1
                end
            end
            if (port_evt.training[p]) begin
                tgtw_nxt[p*2 +: 2] = port_evt.neg_width[p*2 +: 2]; // RQ4
                upcfg_nxt[p] = port_evt.upcfg_seen[p]; // RQ7
            end
            if (wr_go && wb_adr_i == phy_diag_pkg::OFF_TGT_WIDTH
                && wb_sel_i[p]) begin
                // Width cap is the software's job
                tgtw_nxt[p*2 +: 2] = wb_dat_i[p*8 +: 2]; // RQ5
            end
            if (port_evt.retrain_req[p]
                && tgtw_r[p*2 +: 2] != port_evt.cur_width[p*2 +: 2]) begin
                cfg_nxt[p] = 1'b1; // RQ6
            end
            if (wr_go && wb_adr_i == phy_diag_pkg::OFF_PHY_EXTRA
                && wb_sel_i[0] && wb_dat_i[p]) begin
                lbfail_nxt[p] = 1'b0;
            end
            if (port_evt.lb_fail[p]) begin
                lbfail_nxt[p] = 1'b1; // RQ8
                ists_nxt[phy_diag_pkg::IRQ_LBFAIL_LSB + p] = 1'b1;
            end
            if (sync_w[p] && !sync_d_r[p]) begin
                ists_nxt[phy_diag_pkg::IRQ_SYNC_LSB + p] = 1'b1;
            end
            if (sat_evt[p]) begin
                ists_nxt[phy_diag_pkg::IRQ_SAT_LSB + p] = 1'b1;
            end
        end
        if (wr_go && wb_adr_i == phy_diag_pkg::OFF_PHY_EXTRA) begin
            if (wb_sel_i[2]) begin
                extlb_nxt = wb_dat_i[phy_diag_pkg::PX_EXTLB_LSB +: 4];
                rxdet_nxt = wb_dat_i[phy_diag_pkg::PX_RXDET_LSB +: 4];
            end
            if (wb_sel_i[3]) begin
                mcsel_nxt = wb_dat_i[phy_diag_pkg::PX_MCSEL_LSB +: 2];
            end
        end
        if (wr_go && wb_adr_i == phy_diag_pkg::OFF_PAT_SYNC
            && wb_sel_i[2]) begin
            inv_nxt = wb_dat_i[phy_diag_pkg::PS_INVERT_BIT]; // RQ16
        end
        if (wr_go && wb_adr_i == phy_diag_pkg::OFF_IRQ_MASK) begin
            imask_nxt = wb_dat_i[11:0];
        end
        if (wr_go && wb_adr_i == phy_diag_pkg::OFF_PAT_CTRL
            && wb_sel_i[0]) begin
            gen_en_nxt = wb_dat_i[phy_diag_pkg::PC_GEN_EN_BIT];
            chk_en_nxt = wb_dat_i[phy_diag_pkg::PC_CHK_EN_BIT];
        end
        // Compliance counter counts lane_st.mc_err regardless of the lane select, and saturates
        if (lane_st.mc_err && mccnt_r != phy_diag_pkg::MC_MAX) begin
            mccnt_nxt = mccnt_r + 7'h01; // RQ11
        end
        if (!chk_en_r) begin
            chkcnt_nxt = phy_diag_pkg::CNT_RST; // RQ17
        end else if (|err_w && chkcnt_r != phy_diag_pkg::CNT_MAX) begin
            chkcnt_nxt = chkcnt_r + 8'h01; // RQ17
        end
        if (!gen_en_r) begin
            prbs_nxt = phy_diag_pkg::PRBS_SEED;
            tx_nxt   = 7'h00;
        end else begin
            prbs_nxt = {prbs_r[5:0], prbs_r[6] ^ prbs_r[5]};
            tx_nxt   = inv_r ? ~prbs_r : prbs_r; // RQ16
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxerr_r  <= 32'h0000_0000;
            tgtw_r   <= 8'h00;
            upcfg_r  <= 4'h0;
            lbfail_r <= 4'h0;
            extlb_r  <= 4'h0;
            rxdet_r  <= 4'h0;
            mcsel_r  <= 2'h0;
            mccnt_r  <= phy_diag_pkg::MC_RST;
            mclock_r <= 1'b0;
            inv_r    <= 1'b0;
            gen_en_r <= 1'b0;
            chk_en_r <= 1'b0;
            chkcnt_r <= phy_diag_pkg::CNT_RST;
            prbs_r   <= phy_diag_pkg::PRBS_SEED;
            tx_r     <= 7'h00;
            cfg_r    <= 4'h0;
            ists_r   <= 12'h000;
            imask_r  <= 12'h000;
            rdat_r   <= 32'h0000_0000;
            ack_r    <= 1'b0;
            sync_d_r <= 4'h0;
        end else begin
            rxerr_r  <= rxerr_nxt;
            tgtw_r   <= tgtw_nxt;
            upcfg_r  <= upcfg_nxt;
            lbfail_r <= lbfail_nxt;
            extlb_r  <= extlb_nxt;
            rxdet_r  <= rxdet_nxt;
            mcsel_r  <= mcsel_nxt;
            mccnt_r  <= mccnt_nxt;
            mclock_r <= mclock_nxt;
            inv_r    <= inv_nxt;
            gen_en_r <= gen_en_nxt;
            chk_en_r <= chk_en_nxt;
            chkcnt_r <= chkcnt_nxt;
            prbs_r   <= prbs_nxt;
            tx_r     <= tx_nxt;
            cfg_r    <= cfg_nxt;
            ists_r   <= ists_nxt;
            imask_r  <= imask_nxt;
            rdat_r   <= rdat_nxt;
            ack_r    <= ack_nxt;
            sync_d_r <= sync_w;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign tx_word  = tx_r;
    assign irq      = |(ists_r & imask_r);
    assign port_ctrl = {cfg_r, tgtw_r, extlb_r, // RQ12
                        lbfail_r & port_evt.ready_lb_master}; // RQ9
    ////////////////////////////////////////////////////////////////////
    // Checks
    chk_cnt_saturate: assert property ( // RQ1
        rxerr_r[31:24] == 8'hFF && !rxclr_w[3] |=> rxerr_r[31:24] == 8'hFF)
        else $error("port 3 error count left saturation");
    chk_cnt_clear: assert property ( // RQ2
        rxclr_w[2] |=> rxerr_r[23:16] == 8'h00)
        else $error("byte write did not clear count");
    chk_cnt_step: assert property ( // RQ3
        port_evt.rx_err[2] && rxerr_r[23:16] != 8'hFF && !rxclr_w[2]
        |=> rxerr_r[23:16] == $past(rxerr_r[23:16]) + 8'h01)
        else $error("count did not step by one");
    chk_width_load: assert property ( // RQ4
        port_evt.training[0] && !wr_go
        |=> tgtw_r[1:0] == $past(port_evt.neg_width[1:0]))
        else $error("target width not loaded");
    chk_retrain_cfg: assert property ( // RQ6
        port_evt.retrain_req[1] && tgtw_r[3:2] != port_evt.cur_width[3:2]
        |=> port_ctrl.ltssm_to_cfg[1])
        else $error("no configuration request on retrain");
    chk_upcfg_flag: assert property ( // RQ7
        port_evt.training[3] |=> upcfg_r[3] == $past(port_evt.upcfg_seen[3]))
        else $error("upconfigure flag wrong");
    chk_lbfail_set: assert property ( // RQ8
        port_evt.lb_fail[3] |=> lbfail_r[3])
        else $error("loopback failure not flagged");
    chk_chk_clear: assert property ( // RQ17
        !chk_en_r |=> chkcnt_r == 8'h00)
        else $error("checker count not cleared");
    chk_prbs_invert: assert property ( // RQ16
        gen_en_r && inv_r |=> tx_word == ~$past(prbs_r))
        else $error("pattern not inverted");
    chk_irq_set: assert property (
        port_evt.lb_fail[1] |=> ists_r[phy_diag_pkg::IRQ_LBFAIL_LSB + 1])
        else $error("interrupt status not set by event");
    cov_saturate: cover property (rxerr_r[31:24] == 8'hFF);
    cov_sync: cover property (sync_w[0]);
    cov_retrain: cover property (|cfg_r);

endmodule

/* File: design/prbs_lane_checker.sv */
/*
 * One lane of the PRBS7 pattern checker.  Locks after two consecutive
 * received words match the local prediction; errors count only in sync.
 * Assumes one received 7-bit word per valid cycle on the core clock.
 */
`timescale 1ns/1ps

module prbs_lane_checker (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       invert,
    input  wire logic       rx_valid,
    input  wire logic [6:0] rx_word,
    output logic            sync,
    output logic            err_pulse
);

    logic [6:0] pred_r;
    logic [6:0] pred_nxt;
    logic [1:0] match_r;
    logic [1:0] match_nxt;
    logic       sync_r;
    logic       sync_nxt;
    logic       err_r;
    logic       err_nxt;
    logic [6:0] rx_plain;
    logic [6:0] rx_step;

    function automatic logic [6:0] prbs_next(input logic [6:0] s);
        prbs_next = {s[5:0], s[6] ^ s[5]};
    endfunction

    always_comb begin
        rx_plain  = invert ? ~rx_word : rx_word;
        rx_step   = prbs_next(rx_plain);
        pred_nxt  = pred_r;
        match_nxt = match_r;
        sync_nxt  = sync_r;
        err_nxt   = 1'b0;
        if (!enable) begin
            match_nxt = 2'h0;
            sync_nxt  = 1'b0;
        end else if (rx_valid) begin
            pred_nxt = rx_step;
            if (sync_r) begin
                // Errors exist only once locked
                err_nxt = (rx_plain != pred_r); // RQ15
            end else if (rx_plain == pred_r) begin
                match_nxt = match_r + 2'h1;
                if (match_nxt == 2'(phy_diag_pkg::SYNC_MATCHES)) begin
                    sync_nxt = 1'b1; // RQ14
                end
            end else begin
                match_nxt = 2'h0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pred_r  <= 7'h00;
            match_r <= 2'h0;
            sync_r  <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            pred_r  <= pred_nxt;
            match_r <= match_nxt;
            sync_r  <= sync_nxt;
            err_r   <= err_nxt;
        end
    end

    assign sync      = sync_r;
    assign err_pulse = err_r;

endmodule

/* File: test/lane_partner.sv */
/* Loopback link partner: echoes the generator word on every lane, inverted where bad_lane is set.
   Assumes one core clock; a zero word means the generator is off. */
`timescale 1ns/1ps

module lane_partner (
    input  wire logic        clk_sys,
    input  wire logic [6:0]  tx_word,
    input  wire logic [3:0]  bad_lane,
    output logic      [3:0]  rx_valid = 4'h0,
    output logic      [27:0] rx_words = 28'h0
);
    logic [6:0] junk_r = 7'h2A;
    ////////////////////////////////////////
    // Idle lanes toggle, so a stale word never passes for a match
    always_ff @(posedge clk_sys) begin
        junk_r <= ~junk_r;
        rx_valid <= {4{tx_word != 7'h00}};
        for (int l = 0; l < 4; l++) begin
            rx_words[7*l +: 7] <= (tx_word == 7'h00) ? junk_r
                                : bad_lane[l] ? ~tx_word : tx_word;
        end
    end
endmodule

/* File: test/tb_top.sv */
/* Random and corner-case bench for the diagnostic status block.
   Assumes the loopback partner and a one-cycle Wishbone answer. */
`timescale 1ns/1ps

module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [3:0]  rx_valid;
    logic [27:0] rx_words;
    logic [6:0]  tx_word;
    logic        irq;
    logic [3:0]  bad_lane = 4'h0;
    logic [31:0] rd;
    logic [31:0] ex;
    logic [7:0]  cnt [4];
    logic [7:0]  nw;
    logic [7:0]  tw;
    logic [3:0]  ev;
    logic [6:0]  pv;
    logic [6:0]  e7;
    logic        ia;
    int          n_errors = 0;
    int          samples_checked = 0;

    phy_diag_pkg::port_event_type  port_evt = '0;
    phy_diag_pkg::lane_status_type lane_st = '0;
    phy_diag_pkg::port_ctrl_type   port_ctrl;

    phy_link_diagnostic_status dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .port_evt(port_evt), .lane_st(lane_st),
        .rx_valid(rx_valid), .rx_words(rx_words),
        .port_ctrl(port_ctrl), .tx_word(tx_word), .irq(irq));
    lane_partner partner (.clk_sys(clk_sys), .tx_word(tx_word),
        .bad_lane(bad_lane), .rx_valid(rx_valid), .rx_words(rx_words));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic [6:0] step(logic [6:0] s);
        return {s[5:0], s[6] ^ s[5]};
    endfunction

    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic wb(logic we, logic [11:0] a, logic [3:0] s,
                      logic [31:0] d);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) begin
            chk("ack", 32'h1, 32'h0);
            report_and_stop();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic pat(logic inv);
        for (int k = 0; k < 12; k++) begin
            @(negedge clk_sys);
            pv = tx_word;
            @(negedge clk_sys);
            e7 = inv ? ~step(~pv) : step(pv);
            chk("tx", e7, tx_word);
        end
        @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(89));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        wb(0, phy_diag_pkg::OFF_RX_ERR, 4'hF, 32'h0);
        chk("rx rst", 32'h0, rd);
        cnt = '{default: 8'h00};
        for (int k = 0; k < 300; k++) begin
            ev = {1'b1, 3'($urandom)};
            port_evt.rx_err <= ev;
            for (int p = 0; p < 4; p++)
                if (ev[p] && cnt[p] != 8'hFF) cnt[p]++;
            @(posedge clk_sys);
        end
        port_evt.rx_err <= 4'h0;
        @(posedge clk_sys);
        wb(0, phy_diag_pkg::OFF_RX_ERR, 4'hF, 32'h0);
        chk("rx", {cnt[3], cnt[2], cnt[1], cnt[0]}, rd);
        wb(1, phy_diag_pkg::OFF_RX_ERR, 4'h5, $urandom);
        wb(0, phy_diag_pkg::OFF_RX_ERR, 4'hF, 32'h0);
        chk("rx clr", {cnt[3], 8'h00, cnt[1], 8'h00}, rd);
        nw = 8'($urandom) | 8'h0C;
        ev = 4'($urandom);
        port_evt.neg_width <= nw;
        port_evt.upcfg_seen <= ev;
        port_evt.training <= 4'hF;
        @(posedge clk_sys);
        port_evt.training <= 4'h0;
        @(posedge clk_sys);
        wb(0, phy_diag_pkg::OFF_TGT_WIDTH, 4'hF, 32'h0);
        for (int p = 0; p < 4; p++)
            ex[8*p +: 8] = {ev[p], 5'h00, nw[2*p +: 2]};
        chk("width", ex, rd);
        // Never wider than negotiated
        tw = nw & 8'($urandom) & 8'hF7;
        for (int p = 0; p < 4; p++)
            ex[8*p +: 8] = {6'h00, tw[2*p +: 2]};
        wb(1, phy_diag_pkg::OFF_TGT_WIDTH, 4'hF, ex);
        port_evt.cur_width <= nw;
        port_evt.retrain_req <= 4'hF;
        @(posedge clk_sys);
        port_evt.retrain_req <= 4'h0;
        @(negedge clk_sys);
        for (int p = 0; p < 4; p++)
            ev[p] = tw[2*p +: 2] != nw[2*p +: 2];
        chk("to cfg", ev, port_ctrl.ltssm_to_cfg);
        chk("tgt", tw, port_ctrl.target_width);
        @(posedge clk_sys);
        ev = 4'($urandom);
        lane_st.phy_status <= ev;
        port_evt.ready_lb_master <= 4'h6;
        port_evt.lb_fail <= 4'hA;
        @(posedge clk_sys);
        port_evt.lb_fail <= 4'h0;
        @(posedge clk_sys);
        wb(0, phy_diag_pkg::OFF_PHY_EXTRA, 4'hF, 32'h0);
        chk("lb", {ev, 4'hA}, rd[7:0]);
        chk("lb+rdy", 4'h2, port_ctrl.lb_after_fail);
        wb(1, phy_diag_pkg::OFF_PHY_EXTRA, 4'h1, 32'h2);
        wb(0, phy_diag_pkg::OFF_PHY_EXTRA, 4'hF, 32'h0);
        chk("lb w1c", 4'h8, rd[3:0]);
        wb(0, phy_diag_pkg::OFF_IRQ_STATUS, 4'hF, 32'h0);
        chk("irq st", 32'h80A, rd);
        port_evt.lb_fail <= 4'h4;
        @(posedge clk_sys);
        port_evt.lb_fail <= 4'h0;
        wb(1, phy_diag_pkg::OFF_IRQ_MASK, 4'hF, 32'h0);
        ia = irq;
        wb(1, phy_diag_pkg::OFF_IRQ_MASK, 4'hF, 32'hFFF);
        chk("irq mask", 32'h1, ia ^ irq);
        wb(0, phy_diag_pkg::OFF_IRQ_STATUS, 4'hF, 32'h0);
        chk("irq rd", 32'h4, rd);
        chk("irq clr", 32'h0, irq);
        ev = 4'($urandom);
        wb(1, phy_diag_pkg::OFF_PHY_EXTRA, 4'hC,
           {8'h02, 4'h0, ev, 16'h0});
        lane_st.mc_lock <= 1'b1;
        lane_st.mc_err <= 1'b1;
        repeat (5) @(posedge clk_sys);
        lane_st.mc_err <= 1'b0;
        @(posedge clk_sys);
        wb(0, phy_diag_pkg::OFF_PHY_EXTRA, 4'hF, 32'h0);
        chk("extra", {8'h02, 4'h0, ev, 8'h85}, rd[31:8]);
        chk("ext lb", ev, port_ctrl.ext_loopback);
        bad_lane <= 4'h8;
        wb(1, phy_diag_pkg::OFF_PAT_CTRL, 4'h1, 32'h3);
        rd = 32'h0;
        for (int i = 0; i < 30 && rd[2:0] !== 3'h7; i++)
            wb(0, phy_diag_pkg::OFF_PAT_SYNC, 4'hF, 32'h0);
        chk("sync", 32'h7, rd);
        wb(0, phy_diag_pkg::OFF_PAT_CTRL, 4'hF, 32'h0);
        chk("no cnt", 32'h3, rd);
        pat(1'b0);
        bad_lane <= 4'h9;
        @(posedge clk_sys);
        bad_lane <= 4'h8;
        repeat (3) @(posedge clk_sys);
        wb(0, phy_diag_pkg::OFF_PAT_CTRL, 4'hF, 32'h0);
        chk("errs", 32'h2, rd[15:8]);
        wb(1, phy_diag_pkg::OFF_PAT_CTRL, 4'h1, 32'h1);
        wb(0, phy_diag_pkg::OFF_PAT_CTRL, 4'hF, 32'h0);
        chk("cnt clr", 32'h1, rd);
        wb(1, phy_diag_pkg::OFF_PAT_SYNC, 4'h4, 32'h10000);
        wb(0, phy_diag_pkg::OFF_PAT_SYNC, 4'hF, 32'h0);
        chk("inv", 32'h1, rd[16]);
        pat(1'b1);
        wb(1, 12'h300, 4'hF, 32'hFFFFFFFF);
        wb(0, 12'h300, 4'hF, 32'h0);
        chk("unmapped", 32'h0, rd);
        report_and_stop();
    end
endmodule
